//--- inc/acr_cfg.svh
// constants for the converter clock and reference mode control block
// assumes a 25 mhz system clock and an axi4-lite register master
//
// Overview of operation
// R1 - mode 01: internal clock, start pin times acquisition
// R2 - mode 11: serial clock converts, host keeps <=4.8MHz
// R3 - modes 00/10 internal timing; pin role by mode
// R4 - wake delays count internal ticks in 00/01/10
// R5 - ref 00: shut after scan, wake 218 cycles
// R6 - ref 10 default, same shutdown, 218 wake
// R7 - ref 01/11 analog only: no internal reference
// R8 - temperature forces reference on, waits 244 cycles
// R9 - mode 11 temperature wake: 244 serial clocks
// R10 - mode 11 temperature ready 188 clocks later
// R11 - mode 11 ref 00: shut, rewake 218 clocks
// R12 - ref 00/10 pin is analog 6, else reference
// R13 - host starts scan by command or pin pulse
// R14 - clock mode bits 5:4, reference bits 3:2
// R15 - upper clock mode bit resets to one
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// register byte addresses
`define ACR_ADDR_SETUP   8'h00
`define ACR_ADDR_CONV    8'h04
`define ACR_ADDR_STATUS  8'h08

// setup field positions and reset value
`define ACR_CLK_HI       5
`define ACR_CLK_LO       4
`define ACR_REF_HI       3
`define ACR_REF_LO       2
`define ACR_CLK_RESET    2'h2
`define ACR_REF_RESET    2'h2

// conversion command field
`define ACR_CONV_TEMP    0

// axi responses
`define ACR_RESP_OKAY    2'h0
`define ACR_RESP_SLVERR  2'h2

// wake and latency counts in conversion clock ticks
`define ACR_WAKE_AIN     8'hda
`define ACR_WAKE_TEMP    8'hf4
`define ACR_TEMP_LAT     8'hbc

// timing
`define ACR_ACLK_KHZ     25000
`define ACR_SCLK_MAX_KHZ 4800
`define ACR_SCLK_MIN_GAP 4'(`ACR_ACLK_KHZ / `ACR_SCLK_MAX_KHZ)
`define ACR_ICLK_DIV     4'h3

`endif

//--- inc/acr_pkg.sv
// types shared by the clock and reference mode control block
// assumes acr_cfg.svh is on the include path
`default_nettype none

package acr_pkg;

  // scan sequencer states
  typedef enum logic [1:0] {ACR_IDLE, ACR_WAKE, ACR_TLAT, ACR_CONV} acr_seq_e;

  // register selected by an address
  typedef enum logic [1:0] {ACR_R_SETUP, ACR_R_CONV, ACR_R_STATUS,
                            ACR_R_NONE} acr_reg_e;

  // axi4-lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } acr_axi_req_s;

  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } acr_axi_rsp_s;

  // controls toward the converter core and pin muxes
  typedef struct packed {
    logic ref_enable;
    logic ext_conv_clk;
    logic acq_by_pin;
    logic acq_by_sclk;
    logic pin7_is_start;
    logic adc_ext_ref_pin_is_analog_in_6;
    logic conv_go;
    logic temp_ready;
    logic busy;
  } acr_ctl_s;

endpackage

`default_nettype wire

//--- hw/acr_sync.sv
// two flip-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to aclk
`default_nettype none

module acr_sync
  import acr_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } acr_sync_st_s;

  acr_sync_st_s st;
  acr_sync_st_s next_st;

  // shift the level through two stages
  always_comb
  begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign q = st.s2;

endmodule

`default_nettype wire

//--- hw/acr_wake_timer.sv
// down counter for reference wake and temperature latency delays
// assumes tick is a one-cycle pulse per conversion clock period
`default_nettype none

module acr_wake_timer
  import acr_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       tick,
  output logic            done
);

  typedef struct packed {
    logic       busy;
    logic [7:0] cnt;
    logic       done;
  } acr_tmr_st_s;

  acr_tmr_st_s st;
  acr_tmr_st_s next_st;

  // load, then count ticks down and pulse done on the last one
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (load)
    begin
      next_st.busy = 1'b1;
      next_st.cnt = load_val;
    end
    else if (st.busy && tick)
    begin
      next_st.cnt = st.cnt - 8'h01;
      if (st.cnt == 8'h01)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign done = st.done;

endmodule

`default_nettype wire

//--- hw/acr_top.sv
// clock mode and reference mode control with axi4-lite registers
// assumes a converter core that pulses scan_done and pins that are
// asynchronous to aclk (start pin, host serial clock)
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
`include "acr_cfg.svh"

module acr_top
  import acr_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire acr_axi_req_s  axi_req,
  output acr_axi_rsp_s       axi_rsp,
  input  wire logic          conv_start_pin_n,
  input  wire logic          sclk,
  input  wire logic          scan_done,
  output acr_ctl_s           ctl
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  clock_mode;
    logic [1:0]  ref_mode;
    logic        temp_req;
    logic        ref_on;
    logic        tmr_temp;
    acr_seq_e    seq;
    logic        conv_go;
    logic        temp_ready;
    logic        sclk_fast;
    logic [3:0]  sclk_gap;
    logic [3:0]  div;
    logic        start_prev;
    logic        sclk_prev;
  } acr_top_st_s;

  acr_top_st_s st;
  acr_top_st_s next_st;

  logic       start_s;
  logic       sclk_s;
  logic       tick;
  logic       tmr_load;
  logic [7:0] tmr_val;
  logic       tmr_done;

  ////////////////////////////////////////////////////////////////////
  // helpers

  // map a byte address onto a register
  function automatic acr_reg_e reg_sel(input logic [7:0] addr);
    if (addr == `ACR_ADDR_SETUP)
      reg_sel = ACR_R_SETUP;
    else if (addr == `ACR_ADDR_CONV)
      reg_sel = ACR_R_CONV;
    else if (addr == `ACR_ADDR_STATUS)
      reg_sel = ACR_R_STATUS;
    else
      reg_sel = ACR_R_NONE;
  endfunction

  // setup register image, clock mode in 5:4 and reference in 3:2
  function automatic logic [31:0] setup_word(input logic [1:0] ck,
                                             input logic [1:0] rf);
    setup_word = 32'h0000_0000;
    setup_word[`ACR_CLK_HI:`ACR_CLK_LO] = ck; // R14
    setup_word[`ACR_REF_HI:`ACR_REF_LO] = rf; // R14
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and delay timer

  // start pin and serial clock come from outside the aclk domain
  acr_sync u_sync_start (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (conv_start_pin_n),
    .q       (start_s)
  );

  acr_sync u_sync_sclk (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (sclk),
    .q       (sclk_s)
  );

  acr_wake_timer u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .load     (tmr_load),
    .load_val (tmr_val),
    .tick     (tick),
    .done     (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////
  // conversion clock tick selection

  // mode 11 counts host serial clock edges, others the internal clock
  always_comb
  begin
    if (st.clock_mode == 2'h3)
      tick = sclk_s && !st.sclk_prev; // R2 R9 R10 R11
    else
      tick = (st.div == 4'h0); // R4
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic     start_req;
    logic     need_ref;
    logic     fall;
    logic     sclk_rise;
    acr_reg_e wsel;
    acr_reg_e rsel;

    start_req = 1'b0;
    need_ref = 1'b0;
    fall = 1'b0;
    sclk_rise = 1'b0;
    wsel = ACR_R_NONE;
    rsel = ACR_R_NONE;
    next_st = st;
    next_st.conv_go = 1'b0;
    next_st.temp_ready = 1'b0;
    tmr_load = 1'b0;
    tmr_val = `ACR_WAKE_AIN;

    // edge detection on synchronised pins
    fall = st.start_prev && !start_s;
    sclk_rise = sclk_s && !st.sclk_prev;
    next_st.start_prev = start_s;
    next_st.sclk_prev = sclk_s;

    // internal conversion clock divider
    if (st.div == 4'h0)
      next_st.div = `ACR_ICLK_DIV;
    else
      next_st.div = st.div - 4'h1;

    // write address and data are taken in either order
    if (axi_req.awvalid && !st.aw_got && !st.bvalid)
    begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st.w_got && !st.bvalid)
    begin
      next_st.w_got = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_lane0 = axi_req.wstrb[0];
    end

    // perform the write once both halves are held
    if (st.aw_got && st.w_got)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `ACR_RESP_OKAY;
      wsel = reg_sel(st.aw_addr);
      if (wsel == ACR_R_SETUP)
      begin
        if (st.w_lane0)
        begin
          next_st.clock_mode =
            st.w_data[`ACR_CLK_HI:`ACR_CLK_LO]; // R14
          next_st.ref_mode =
            st.w_data[`ACR_REF_HI:`ACR_REF_LO]; // R14
          next_st.sclk_fast = 1'b0;
        end
      end
      else if (wsel == ACR_R_CONV)
      begin
        if (st.w_lane0 && st.seq == ACR_IDLE)
        begin
          next_st.temp_req = st.w_data[`ACR_CONV_TEMP];
          // command start only in modes 10 and 11
          start_req = st.clock_mode[1]; // R13
        end
      end
      else
        next_st.bresp = `ACR_RESP_SLVERR;
    end
    if (st.bvalid && axi_req.bready)
      next_st.bvalid = 1'b0;

    // serial clock period watch, flags a clock faster than allowed;
    // placed after the setup write so a fresh hit beats the clear
    if (sclk_rise)
    begin
      next_st.sclk_gap = 4'h0;
      if (st.clock_mode == 2'h3 && st.seq != ACR_IDLE &&
          st.sclk_gap < `ACR_SCLK_MIN_GAP - 4'h1)
        next_st.sclk_fast = 1'b1; // R2
    end
    else if (st.sclk_gap != 4'hf)
      next_st.sclk_gap = st.sclk_gap + 4'h1;

    // reads answer one cycle after the address is taken
    if (axi_req.arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `ACR_RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      rsel = reg_sel(axi_req.araddr);
      if (rsel == ACR_R_SETUP)
        next_st.rdata = setup_word(st.clock_mode, st.ref_mode);
      else if (rsel == ACR_R_CONV)
        next_st.rdata[`ACR_CONV_TEMP] = st.temp_req;
      else if (rsel == ACR_R_STATUS)
        next_st.rdata[7:0] = {st.seq, st.sclk_fast, st.ref_on,
                              ~st.ref_mode[0], ~st.clock_mode[1],
                              st.clock_mode == 2'h3,
                              st.seq != ACR_IDLE};
      else
        next_st.rresp = `ACR_RESP_SLVERR;
    end
    else if (st.rvalid && axi_req.rready)
      next_st.rvalid = 1'b0;

    // pin start only in modes 00 and 01
    if (fall && !st.clock_mode[1] && st.seq == ACR_IDLE)
      start_req = 1'b1; // R1 R3 R13

    // analog channels use the internal reference in ref 00 and 10 only
    need_ref = next_st.temp_req || !st.ref_mode[0]; // R7 R8

    // scan sequencer
    case (st.seq)
      ACR_IDLE:
      begin
        if (start_req)
        begin
          if (need_ref && !st.ref_on)
          begin
            next_st.ref_on = 1'b1; // R5 R6 R8
            next_st.seq = ACR_WAKE;
            next_st.tmr_temp = next_st.temp_req;
            tmr_load = 1'b1;
            if (next_st.temp_req)
              tmr_val = `ACR_WAKE_TEMP; // R8 R9
            else
              tmr_val = `ACR_WAKE_AIN; // R5 R6 R11
          end
          else
          begin
            next_st.conv_go = 1'b1; // R7
            next_st.seq = ACR_CONV;
          end
        end
      end
      ACR_WAKE:
      begin
        if (tmr_done)
        begin
          if (st.tmr_temp && st.clock_mode == 2'h3)
          begin
            next_st.seq = ACR_TLAT;
            tmr_load = 1'b1;
            tmr_val = `ACR_TEMP_LAT; // R10
          end
          else
          begin
            next_st.conv_go = 1'b1;
            next_st.temp_ready = st.tmr_temp;
            next_st.seq = ACR_CONV;
          end
        end
      end
      ACR_TLAT:
      begin
        if (tmr_done)
        begin
          next_st.temp_ready = 1'b1; // R10
          next_st.conv_go = 1'b1;
          next_st.seq = ACR_CONV;
        end
      end
      ACR_CONV:
      begin
        if (scan_done)
        begin
          next_st.ref_on = 1'b0; // R5 R6 R11
          next_st.seq = ACR_IDLE;
        end
      end
      default:
        next_st.seq = ACR_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.clock_mode <= `ACR_CLK_RESET; // R15
      st.ref_mode <= `ACR_REF_RESET; // R6
      st.div <= `ACR_ICLK_DIV;
      st.start_prev <= 1'b0; // same as synchroniser reset, no false edge
      st.sclk_gap <= 4'hf;
      st.seq <= ACR_IDLE;
    end
    else if (ce)
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////
  // bus answers

  // ready terms are combinational, data and responses from flops
  always_comb
  begin
    axi_rsp.awready = !st.aw_got && !st.bvalid;
    axi_rsp.wready = !st.w_got && !st.bvalid;
    axi_rsp.bvalid = st.bvalid;
    axi_rsp.bresp = st.bresp;
    axi_rsp.arready = !st.rvalid;
    axi_rsp.rvalid = st.rvalid;
    axi_rsp.rdata = st.rdata;
    axi_rsp.rresp = st.rresp;
  end

  ////////////////////////////////////////////////////////////////////
  // converter controls

  always_comb
  begin
    ctl.ref_enable = st.ref_on; // R5 R7 R8
    ctl.ext_conv_clk = (st.clock_mode == 2'h3); // R2
    ctl.acq_by_pin = (st.clock_mode == 2'h1); // R1
    ctl.acq_by_sclk = (st.clock_mode == 2'h3); // R2
    ctl.pin7_is_start = !st.clock_mode[1]; // R3
    ctl.adc_ext_ref_pin_is_analog_in_6 = !st.ref_mode[0]; // R12
    ctl.conv_go = st.conv_go;
    ctl.temp_ready = st.temp_ready;
    ctl.busy = (st.seq != ACR_IDLE);
  end

endmodule

`default_nettype wire

//--- tb/acr_chk.sv
// assertions on the clock and reference mode control outputs
// assumes it is bound to acr_top and watches its ports only
`default_nettype none

module acr_chk
  import acr_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         ce,
  input wire acr_axi_req_s axi_req,
  input wire acr_axi_rsp_s axi_rsp,
  input wire logic         conv_start_pin_n,
  input wire logic         sclk,
  input wire logic         scan_done,
  input wire acr_ctl_s     ctl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [10:0] busy_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // cycles spent busy in the current scan, saturating
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctl.busy)
      busy_cnt <= 11'h000;
    else if (busy_cnt != 11'h7ff)
      busy_cnt <= busy_cnt + 11'h001;
  end

  // a scan leaves idle
  sequence s_start;
    $rose(ctl.busy);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_sclk_mode_pins:
    assert property (ctl.acq_by_sclk |-> ctl.ext_conv_clk
                     && !ctl.pin7_is_start)
    else $error("serial clock mode pin roles wrong");
  a_pin_acq_mode:
    assert property (ctl.acq_by_pin |-> ctl.pin7_is_start && !ctl.ext_conv_clk)
    else $error("pin timed mode not on internal clock");
  a_ref_on_start:
    assert property (s_start ##0 ctl.adc_ext_ref_pin_is_analog_in_6 |-> ctl.ref_enable)
    else $error("reference not woken at scan start");
  a_ext_ref_fast:
    assert property (s_start ##0 (!ctl.adc_ext_ref_pin_is_analog_in_6 && !ctl.ref_enable)
                     |-> ##[0:2] ctl.conv_go)
    else $error("external reference scan waited");
  a_ref_off_done:
    assert property (scan_done && ctl.busy |=> !ctl.ref_enable && !ctl.busy)
    else $error("reference left on after scan");
  a_wake_count:
    assert property (ctl.conv_go && ctl.ref_enable && !ctl.ext_conv_clk
                     |-> busy_cnt >= 11'h35c && busy_cnt <= 11'h3de)
    else $error("wake delay out of range");
  a_temp_go_pair:
    assert property (ctl.temp_ready && !ctl.ext_conv_clk |-> ctl.conv_go)
    else $error("temperature ready without go");
  a_temp_ref_on:
    assert property (ctl.temp_ready |-> ctl.ref_enable)
    else $error("temperature without reference");
  a_reset_modes:
    assert property ($rose(aresetn) |-> !ctl.pin7_is_start
                     && !ctl.ext_conv_clk && ctl.adc_ext_ref_pin_is_analog_in_6)
    else $error("modes wrong after reset");
endmodule

bind acr_top acr_chk acr_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .conv_start_pin_n(conv_start_pin_n), .sclk(sclk),
  .scan_done(scan_done), .ctl(ctl));

`default_nettype wire

//--- tb/acr_host.sv
// host model: framed serial clock and start pin pulses
// assumes the bench sets run around each external clock scan
`default_nettype none

module acr_host
(
  output logic sclk,
  output logic conv_start_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic run = 1'h0;
  int   rises = 0;

  initial
  begin
    sclk = 1'h0;
    conv_start_pin_n = 1'h1;
  end

  // 320 ns clock only inside a frame, idle low
  always
  begin
    wait (run);
    #7;
    while (run)
    begin
      #160;
      // no rise once the frame has closed
      if (run)
      begin
        sclk = 1'h1;
        rises++;
      end
      #160 sclk = 1'h0;
    end
  end

  // low pulse on the start pin
  task start_pulse();
    #3 conv_start_pin_n = 1'h0;
    #200 conv_start_pin_n = 1'h1;
  endtask

  // four rises at a 160 ns period, above the allowed rate, off the aclk edges
  task burst();
    #3;
    repeat (4)
    begin
      #80 sclk = 1'h1;
      #80 sclk = 1'h0;
    end
  endtask
endmodule

`default_nettype wire

//--- tb/acr_top_tb.sv
// self-checking bench for the clock and reference mode control
// assumes acr_host drives the start pin and the serial clock
`default_nettype none
`include "acr_cfg.svh"

module acr_top_tb
  import acr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         aclk, aresetn, ce, scan_done, sclk, pin_n;
  acr_axi_req_s req;
  acr_axi_rsp_s rsp;
  acr_ctl_s     ctl;
  logic [31:0]  q;
  logic [1:0]   rs, m, r;
  int           miscompares = 0, n_checks = 0, cyc = 0, go_cyc, go_rise;
  logic         go_seen, go_ref, go_tr;

  acr_top acr_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .axi_req(req), .axi_rsp(rsp), .conv_start_pin_n(pin_n), .sclk(sclk),
    .scan_done(scan_done), .ctl(ctl));
  acr_host acr_host_inst (.sclk(sclk), .conv_start_pin_n(pin_n));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  // records the first go pulse of a scan
  always @(posedge aclk)
  begin
    cyc++;
    if (ctl.conv_go && !go_seen)
    begin
      go_seen = 1'h1;
      go_cyc = cyc;
      go_rise = acr_host_inst.rises;
      go_ref = ctl.ref_enable;
      go_tr = ctl.temp_ready;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one register access, write or read
  task automatic axi(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge aclk);
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.bready <= wr;
    req.arvalid <= !wr;
    req.rready <= !wr;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'h0;
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'h0;
      if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready))
        break;
    end
    q = rsp.rdata;
    rs = wr ? rsp.bresp : rsp.rresp;
    req.bready <= 1'h0;
    req.rready <= 1'h0;
    if (n == 100)
      chk(32'h1, 32'h0);
  endtask

  // one scan: setup, start, measure wake, end with scan done
  task automatic run_scan(input logic [5:0] su, input logic pin, tmp,
                          input logic ron, input int t);
    int c0;
    int e;
    axi(1'h1, `ACR_ADDR_SETUP, {26'h0, su});
    go_seen = 1'h0;
    acr_host_inst.rises = 0;
    c0 = cyc;
    if (pin)
      acr_host_inst.start_pulse();
    else
      axi(1'h1, `ACR_ADDR_CONV, {31'h0, tmp});
    acr_host_inst.run = ctl.ext_conv_clk;
    for (e = 0; e < 5000 && !go_seen; e++)
      @(posedge aclk);
    acr_host_inst.run = 1'h0;
    e = (su[5:4] == 2'h3) ? go_rise - t : go_cyc - c0 - t * 4;
    chk({31'h0, go_seen && e >= ((su[5:4] == 2'h3) ? 0 : -4)
         && e <= ((su[5:4] == 2'h3) ? 1 : 16)}, 32'h1);
    chk({30'h0, go_ref, go_tr}, {30'h0, ron, tmp});
    scan_done <= 1'h1;
    @(posedge aclk);
    scan_done <= 1'h0;
    repeat (2) @(posedge aclk);
    chk({30'h0, ctl.busy, ctl.ref_enable}, 32'h0);
    $display("scan test %h done", su);
  endtask

  task conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, well beyond the expected run
  initial
  begin
    #2000000;
    miscompares++;
    conclude();
  end

  initial
  begin
    req <= '0;
    ce <= 1'h1;
    scan_done <= 1'h0;
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axi(1'h0, `ACR_ADDR_SETUP, 32'h0);
    chk(q, 32'h28);
    axi(1'h0, `ACR_ADDR_STATUS, 32'h0);
    chk(q, 32'h8);
    $display("reset test done");
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:2];
      r = i[1:0];
      axi(1'h1, `ACR_ADDR_SETUP, {26'h0, m, r, 2'h0});
      axi(1'h0, `ACR_ADDR_STATUS, 32'h0);
      chk(q, {28'h0, !r[0], !m[1], m == 2'h3, 1'h0});
      chk({30'h0, ctl.acq_by_pin, ctl.acq_by_sclk},
          {30'h0, m == 2'h1, m == 2'h3});
      axi(1'h0, `ACR_ADDR_SETUP, 32'h0);
      chk(q, {26'h0, m, r, 2'h0});
    end
    $display("mode table test done");
    axi(1'h0, 8'h0c, 32'h0);
    chk({30'h0, rs}, {30'h0, `ACR_RESP_SLVERR});
    axi(1'h1, `ACR_ADDR_STATUS, 32'h0);
    chk({30'h0, rs}, {30'h0, `ACR_RESP_SLVERR});
    $display("refusal test done");
    run_scan(6'h28, 1'h0, 1'h0, 1'h1, 218);
    run_scan(6'h24, 1'h0, 1'h0, 1'h0, 0);
    run_scan(6'h2c, 1'h0, 1'h1, 1'h1, 244);
    run_scan(6'h10, 1'h1, 1'h1, 1'h1, 244);
    run_scan(6'h30, 1'h0, 1'h0, 1'h1, 218);
    run_scan(6'h3c, 1'h0, 1'h1, 1'h1, 432);
    axi(1'h0, `ACR_ADDR_CONV, 32'h0);
    chk(q, 32'h1);
    // mode 11 external reference scan held busy under a too fast clock
    axi(1'h1, `ACR_ADDR_SETUP, 32'h34);
    axi(1'h1, `ACR_ADDR_CONV, 32'h0);
    acr_host_inst.burst();
    axi(1'h0, `ACR_ADDR_STATUS, 32'h0);
    chk(q, 32'he3);
    scan_done <= 1'h1;
    @(posedge aclk);
    scan_done <= 1'h0;
    axi(1'h1, `ACR_ADDR_SETUP, 32'h34);
    axi(1'h0, `ACR_ADDR_STATUS, 32'h0);
    chk(q, 32'h2);
    $display("fast clock test done");
    conclude();
  end
endmodule

`default_nettype wire
